// [rtl/swsts_master.sv]
// Single-wire bus master: reset/presence, write and read time slots with result buffer
`timescale 1ns/1ps
module swsts_master
   import swsts_pkg::*;
#(
   parameter int WRITE_ZERO_LOW_CYC = CYC_WRITE_ZERO_LOW,
   parameter int SLOT_CYC = CYC_SLOT,
   parameter int RESET_LOW_CYC = CYC_RESET_LOW,
   parameter int PRESENCE_SAMPLE_CYC = CYC_PRESENCE_SAMPLE,
   parameter int RESET_SLOT_CYC = CYC_RESET_SLOT
) (
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic enable_in,
   input wire logic cmd_valid_in,
   output logic cmd_ready_out,
   input wire logic [1:0] cmd_code_in,
   input wire logic cmd_bit_in,
   output logic res_valid_out,
   input wire logic res_ready_in,
   output logic [RES_W-1:0] res_data_out,
   output logic busy_out,
   input wire logic line_in,
   output logic line_out,
   output logic line_oe_out
);
   localparam logic [CNT_W-1:0] W1_LOW = CNT_W'(CYC_WRITE_ONE_LOW);
   localparam logic [CNT_W-1:0] RD_LOW = CNT_W'(CYC_READ_LOW);
   localparam logic [CNT_W-1:0] SAMPLE_AT = CNT_W'(CYC_SAMPLE);
   localparam logic [CNT_W-1:0] REC_LEN = CNT_W'(CYC_RECOVERY);
   localparam logic [CNT_W-1:0] W0_LOW = CNT_W'(WRITE_ZERO_LOW_CYC);
   localparam logic [CNT_W-1:0] SLOT_LEN = CNT_W'(SLOT_CYC);
   localparam logic [CNT_W-1:0] RST_LOW = CNT_W'(RESET_LOW_CYC);
   localparam logic [CNT_W-1:0] PRES_AT = CNT_W'(PRESENCE_SAMPLE_CYC);
   localparam logic [CNT_W-1:0] RST_LEN = CNT_W'(RESET_SLOT_CYC);
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

   typedef enum logic [1:0] {ST_IDLE, ST_SLOT, ST_RECOVER} swsts_state_e;

   // Line synchroniser
   logic line_meta;
   logic line_sync;
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         line_meta <= 1'b1;
         line_sync <= 1'b1;
      end else if (enable_in) begin
         line_meta <= line_in;
         line_sync <= line_meta;
      end
   end

   // Result buffer, two entries, head entry presented at the output
   logic [RES_W-1:0] buf_data [0:1];
   logic [1:0] buf_count;
   logic [RES_W-1:0] next_buf_data [0:1];
   logic [1:0] next_buf_count;
   logic push;
   logic [RES_W-1:0] push_data;
   logic pop;
   logic buf_in_ready;

   assign buf_in_ready = (buf_count != 2'h2);
   assign pop = enable_in && res_valid_out && res_ready_in;
   assign res_valid_out = (buf_count != 2'h0);
   assign res_data_out = buf_data[0];

   always_comb begin
      next_buf_data[0] = buf_data[0];
      next_buf_data[1] = buf_data[1];
      next_buf_count = buf_count;
      if (pop) begin
         next_buf_data[0] = buf_data[1];
         next_buf_count = next_buf_count - 2'h1;
      end
      if (push && buf_in_ready) begin
         next_buf_data[next_buf_count[0]] = push_data;
         next_buf_count = next_buf_count + 2'h1;
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         buf_data[0] <= '0;
         buf_data[1] <= '0;
         buf_count <= 2'h0;
      end else if (enable_in) begin
         buf_data[0] <= next_buf_data[0];
         buf_data[1] <= next_buf_data[1];
         buf_count <= next_buf_count;
      end
   end

   // Slot sequencer
   swsts_state_e state;
   swsts_state_e next_state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic [CNT_W-1:0] low_len;
   logic [CNT_W-1:0] next_low_len;
   logic [CNT_W-1:0] sample_at;
   logic [CNT_W-1:0] next_sample_at;
   logic [CNT_W-1:0] slot_len;
   logic [CNT_W-1:0] next_slot_len;
   logic wants_result;
   logic next_wants_result;
   logic is_reset;
   logic next_is_reset;
   logic sampled;
   logic next_sampled;
   logic drive_low;
   logic next_drive_low;
   logic cmd_take;

   // Accept only when a result, if any, is sure to find room
   assign cmd_ready_out = (state == ST_IDLE) && buf_in_ready;
   assign cmd_take = enable_in && cmd_valid_in && cmd_ready_out;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_low_len = low_len;
      next_sample_at = sample_at;
      next_slot_len = slot_len;
      next_wants_result = wants_result;
      next_is_reset = is_reset;
      next_sampled = sampled;
      next_drive_low = 1'b0;
      push = 1'b0;
      push_data = '0;
      push_data[RES_KIND_BIT] = is_reset;
      push_data[RES_VALUE_BIT] = sampled;
      case (state)
         ST_IDLE: begin
            if (cmd_take) begin
               next_state = ST_SLOT;
               next_cnt = CNT_ONE;
               next_drive_low = 1'b1;
               next_sampled = 1'b0;
               next_is_reset = (cmd_code_in == CMD_RESET);
               next_wants_result = (cmd_code_in != CMD_WRITE);
               next_slot_len = SLOT_LEN;
               next_sample_at = SAMPLE_AT;
               if (cmd_code_in == CMD_RESET) begin
                  next_low_len = RST_LOW;
                  next_sample_at = PRES_AT;
                  next_slot_len = RST_LEN;
               end else if (cmd_code_in != CMD_WRITE) begin
                  // Unused code 3 runs as a read, with the short read low time
                  next_low_len = RD_LOW;
               end else if (cmd_bit_in) begin
                  next_low_len = W1_LOW;
               end else begin
                  next_low_len = W0_LOW;
               end
            end
         end
         ST_SLOT: begin
            next_cnt = cnt + CNT_ONE;
            next_drive_low = (next_cnt < low_len);
            if (cnt == sample_at) begin
               // Read: low line means zero; reset: low line means presence
               next_sampled = is_reset ? !line_sync : line_sync;
            end
            if (cnt >= slot_len) begin
               next_state = ST_RECOVER;
               next_cnt = '0;
               next_drive_low = 1'b0;
            end
         end
         ST_RECOVER: begin
            // Recovery time counts only once the line is seen high
            if (!line_sync) begin
               next_cnt = '0;
            end else begin
               next_cnt = cnt + CNT_ONE;
            end
            if (cnt >= REC_LEN) begin
               next_state = ST_IDLE;
               push = wants_result;
            end
         end
         default: begin
            next_state = ST_IDLE;
            next_cnt = '0;
         end
      endcase
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state <= ST_IDLE;
         cnt <= '0;
         low_len <= '0;
         sample_at <= '0;
         slot_len <= '0;
         wants_result <= 1'b0;
         is_reset <= 1'b0;
         sampled <= 1'b0;
         drive_low <= 1'b0;
      end else if (enable_in) begin
         state <= next_state;
         cnt <= next_cnt;
         low_len <= next_low_len;
         sample_at <= next_sample_at;
         slot_len <= next_slot_len;
         wants_result <= next_wants_result;
         is_reset <= next_is_reset;
         sampled <= next_sampled;
         drive_low <= next_drive_low;
      end
   end

   assign line_out = 1'b0;
   assign line_oe_out = drive_low;
   assign busy_out = (state != ST_IDLE);
endmodule

// [rtl/swsts_pkg.sv]
// Constants for the single-wire bus master: timings, cycle counts and command codes
package swsts_pkg;
   localparam int CLK_PERIOD_NS = 5;
   // Times in ns
   localparam int WRITE_ONE_LOW_MAX_NS = 15000;
   localparam int WRITE_ONE_LOW_NS = 6000;
   localparam int WRITE_ZERO_LOW_MIN_NS = 60000;
   localparam int WRITE_ZERO_LOW_WINDOW_NS = 60000;
   localparam int READ_LOW_TIME_NS = 6000;
   localparam int EARLIEST_SAMPLE_INSTANT_NS = 6000;
   localparam int LATEST_SAMPLE_INSTANT_NS = 15000;
   localparam int SAMPLE_INSTANT_NS = 13000;
   localparam int SLOT_TIME_NS = 70000;
   localparam int SLOT_RECOVERY_TIME_NS = 5000;
   localparam int RESET_LOW_NS = 480000;
   localparam int PRESENCE_SAMPLE_NS = 70000;
   localparam int RESET_HIGH_NS = 480000;
   // Cycle counts: least times round up, longest times round down
   localparam int CYC_WRITE_ONE_LOW =
      (WRITE_ONE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_READ_LOW =
      (READ_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_SAMPLE = SAMPLE_INSTANT_NS / CLK_PERIOD_NS;
   localparam int CYC_RECOVERY =
      (SLOT_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_WRITE_ZERO_LOW =
      (WRITE_ZERO_LOW_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_SLOT = (SLOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_RESET_LOW = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_PRESENCE_SAMPLE =
      (RESET_LOW_NS + PRESENCE_SAMPLE_NS) / CLK_PERIOD_NS;
   localparam int CYC_RESET_SLOT =
      (RESET_LOW_NS + RESET_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 18;
   // Commands
   localparam logic [1:0] CMD_RESET = 2'h0;
   localparam logic [1:0] CMD_WRITE = 2'h1;
   localparam logic [1:0] CMD_READ = 2'h2;
   // Result word: bit 1 = set for a reset result, bit 0 = value (presence or read bit)
   localparam int RES_W = 2;
   localparam int RES_KIND_BIT = 1;
   localparam int RES_VALUE_BIT = 0;
endpackage

// [verif/swsts_dev.sv]
// Behavioural device model on the shared line
`timescale 1ns/1ps
module swsts_dev (
   input wire logic clock_in,
   input wire logic line_in,
   input wire logic zero_in,
   input wire logic present_in,
   output logic pull_out,
   output logic wbit_out
);
   int t = -1;
   int low_cnt = 0;
   int pres = -1;
   logic prev = 1'b1;
   initial pull_out = 1'b0;
   initial wbit_out = 1'b0;
   always @(posedge clock_in) begin
      prev <= line_in;
      low_cnt <= line_in ? 0 : low_cnt + 1;
      if (prev && !line_in && !pull_out) t <= 0;
      else if (t >= 0) t <= t + 1;
      if (t == 1400) wbit_out <= line_in;
      if (low_cnt > 700 && line_in && present_in) pres <= 0;
      else if (pres >= 0) pres <= pres + 1;
      // Zero answer pulls until its own timer ends; a one never pulls
      pull_out <= (zero_in && t >= 5 && t < 2800) || (pres >= 20 && pres < 220);
   end
endmodule

// [verif/swsts_chk.sv]
// Port checker for the single-wire master
`timescale 1ns/1ps
module swsts_chk (
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic enable_in,
   input wire logic cmd_valid_in,
   input wire logic cmd_ready_out,
   input wire logic res_valid_out,
   input wire logic res_ready_in,
   input wire logic [1:0] res_data_out,
   input wire logic busy_out,
   input wire logic line_in,
   input wire logic line_out,
   input wire logic line_oe_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rstn_in);
   sequence s_take;
      enable_in && cmd_valid_in && cmd_ready_out;
   endsequence
   a_take_low: assert property (s_take |=> line_oe_out && busy_out) else $error("no slot");
   a_one_slot: assert property (s_take |=> !cmd_ready_out [*4]) else $error("double take");
   a_busy_refuse: assert property (busy_out |-> !cmd_ready_out) else $error("ready busy");
   a_release_busy: assert property ($fell(line_oe_out) |-> busy_out [*8]) else $error("slot cut");
   a_idle_free: assert property (!busy_out |-> !line_oe_out) else $error("idle low");
   a_low_hold: assert property ($rose(line_oe_out) |-> line_oe_out [*8]) else $error("short");
   a_open_drain: assert property (line_out == 1'b0) else $error("driven high");
   a_res_hold: assert property (res_valid_out && !res_ready_in |=>
      res_valid_out && $stable(res_data_out)) else $error("result lost");
   a_recover_high: assert property ($fell(busy_out) |->
      $past(line_in, 2) && !line_oe_out) else $error("no recovery");
endmodule
bind swsts_master swsts_chk chk (.clock_in(clock_in), .rstn_in(rstn_in), .enable_in(enable_in),
   .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .res_valid_out(res_valid_out),
   .res_ready_in(res_ready_in), .res_data_out(res_data_out), .busy_out(busy_out),
   .line_in(line_in), .line_out(line_out), .line_oe_out(line_oe_out));

// [verif/swsts_master_tb.sv]
// Testbench for the single-wire master with a device model
`timescale 1ns/1ps
module swsts_master_tb;
   import swsts_pkg::*;
   logic clock_in = 0, rstn_in = 0, enable_in = 1, cmd_valid_in = 0, cmd_bit_in = 0;
   logic res_ready_in = 0, zero = 0, present = 1, pull, wbit;
   logic [1:0] cmd_code_in = CMD_RESET, bb;
   logic cmd_ready_out, res_valid_out, busy_out, line_out, line_oe_out;
   logic [RES_W-1:0] res_data_out;
   wire line = !(line_oe_out === 1'b1 || pull === 1'b1);
   int n_fail = 0, n_tests = 0, seed = 32'h6bb0, i, j;
   swsts_master #(.WRITE_ZERO_LOW_CYC(1500), .SLOT_CYC(3000), .RESET_LOW_CYC(800),
      .PRESENCE_SAMPLE_CYC(900), .RESET_SLOT_CYC(1600)) DUT (.clock_in(clock_in),
      .rstn_in(rstn_in), .enable_in(enable_in), .cmd_valid_in(cmd_valid_in),
      .cmd_ready_out(cmd_ready_out), .cmd_code_in(cmd_code_in), .cmd_bit_in(cmd_bit_in),
      .res_valid_out(res_valid_out), .res_ready_in(res_ready_in), .res_data_out(res_data_out),
      .busy_out(busy_out), .line_in(line), .line_out(line_out), .line_oe_out(line_oe_out));
   swsts_dev dev (.clock_in(clock_in), .line_in(line), .zero_in(zero), .present_in(present),
      .pull_out(pull), .wbit_out(wbit));
   initial forever #2.5 clock_in = ~clock_in;
   function automatic logic [RES_W-1:0] exp_res(input logic k, input logic v);
      exp_res = {k, v};
   endfunction
   task automatic end_sim;
      $display("fails %0d tests %0d", n_fail, n_tests);
      if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic fail(input string m);
      n_fail++;
      $display("unexpected at %0t: %s", $time, m);
   endtask
   task automatic chk_flag(input logic v, input logic e);
      n_tests++;
      if (v !== e) fail("flag");
   endtask
   task automatic chk_res(input logic [RES_W-1:0] e);
      n_tests++;
      if (res_valid_out !== 1'b1 || res_data_out !== e) fail("result");
      res_ready_in = 1;
      @(posedge clock_in) #1 res_ready_in = 0;
      @(posedge clock_in) #1;
   endtask
   task automatic cmd(input logic [1:0] c, input logic v);
      int k;
      chk_flag(cmd_ready_out, 1'b1);
      cmd_code_in = c;
      cmd_bit_in = v;
      cmd_valid_in = 1;
      @(posedge clock_in) #1 cmd_valid_in = 0;
      for (k = 0; k < 6000 && busy_out !== 1'b0; k++) @(posedge clock_in) #1;
      if (k == 6000) begin
         fail("timeout");
         end_sim;
      end
      @(posedge clock_in) #1;
   endtask
   initial begin
      repeat (8) @(posedge clock_in);
      chk_flag(res_valid_out, 1'b0);
      #1 rstn_in = 1;
      @(posedge clock_in) #1;
      cmd(CMD_RESET, 1'b0);
      chk_res(exp_res(1'b1, 1'b1));
      present = 0;
      cmd(CMD_RESET, 1'b0);
      chk_res(exp_res(1'b1, 1'b0));
      for (i = 0; i < 6; i++) begin
         bb[0] = 1'($random(seed));
         cmd(CMD_WRITE, bb[0]);
         chk_flag(wbit, bb[0]);
      end
      for (i = 0; i < 3; i++) begin
         bb = (i == 0) ? 2'h2 : 2'($random(seed));
         for (j = 0; j < 2; j++) begin
            zero = !bb[j];
            cmd(i == 2 ? 2'h3 : CMD_READ, 1'b0);
            zero = 0;
         end
         cmd_valid_in = 1;
         repeat (5) @(posedge clock_in);
         #1 cmd_valid_in = 0;
         chk_flag(busy_out, 1'b0);
         chk_res(exp_res(1'b0, bb[0]));
         chk_res(exp_res(1'b0, bb[1]));
      end
      // A frozen clock enable must not take the offered command
      enable_in = 0;
      cmd_valid_in = 1;
      repeat (4) @(posedge clock_in);
      #1 enable_in = 1;
      chk_flag(busy_out, 1'b0);
      chk_flag(line_oe_out, 1'b0);
      @(posedge clock_in) #1 cmd_valid_in = 0;
      chk_flag(line_oe_out, 1'b1);
      repeat (10) @(posedge clock_in);
      #1 rstn_in = 0;
      #1 chk_flag(line_oe_out, 1'b0);
      @(posedge clock_in) #1 rstn_in = 1;
      chk_flag(busy_out, 1'b0);
      chk_flag(res_valid_out, 1'b0);
      bb[0] = 1'($random(seed));
      cmd(CMD_WRITE, bb[0]);
      chk_flag(wbit, bb[0]);
      end_sim;
   end
endmodule
